// ---- rtl/ocfl_pkg.sv ----
// constants shared by the overcurrent fault and lock logic
// assumes a single 25 MHz clock and APB register access
package ocfl_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ = 25;
  localparam int BASE_TRIP_NS = 2500;
  localparam int QUAL_ADD_NS [8] = '{0, 400, 2200, 4200, 6200, 8200, 10300, 12700};
  localparam int RELEASE_SETTLE_NS = 1000;
  localparam int RELEASE_SETTLE_CYC = (RELEASE_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 9;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] TRIM_CFG_OFS = 8'h00;
  localparam logic [7:0] FAULT_CFG_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // ==========================================================
  // trim configuration fields
  localparam int GAIN_LSB = 0;
  localparam int GAIN_W = 9;
  localparam int OFFS_LSB = 9;
  localparam int OFFS_W = 9;
  localparam int SIGN_BIT = 21;
  localparam int OT_DIS_BIT = 22;
  localparam int COMM_INH_BIT = 24;
  localparam int WR_LOCK_BIT = 25;
  localparam logic [31:0] TRIM_CFG_RST = 32'h0060_0000;
  localparam logic [31:0] TRIM_CFG_MASK = 32'h0367_ffff;

  // ==========================================================
  // fault configuration fields
  localparam int POS_LIM_LSB = 0;
  localparam int NEG_LIM_LSB = 7;
  localparam int LIM_W = 7;
  localparam int QUAL_LSB = 18;
  localparam int QUAL_W = 3;
  localparam int NEG_DIS_BIT = 21;
  localparam int POS_DIS_BIT = 22;
  localparam int HOLD_BIT = 23;
  localparam int HYST_LSB = 24;
  localparam int HYST_W = 2;
  localparam logic [31:0] FAULT_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] FAULT_CFG_MASK = 32'h03fc_3fff;

  // ==========================================================
  // levels in tenths of a percent of full scale
  localparam int LIM_BASE_PM = 500;
  localparam int LIM_STEP_PM = 16;
  localparam int HYST_PM [4] = '{110, 220, 420, 750};
  localparam int HYST_FLOOR_PM = 250;

  // trip qualification time in cycles, least time rounded up
  function automatic logic [CNT_W-1:0] qual_cycles(input logic [QUAL_W-1:0] code);
    int ns;
    ns = BASE_TRIP_NS + QUAL_ADD_NS[code];
    return CNT_W'((ns * CLK_MHZ + 999) / 1000);
  endfunction

endpackage

// ---- rtl/ocfl_persist.sv ----
// one fault channel: qualify, trip, release with settle or hold
// assumes inputs come from logic on the same clock
`timescale 1ns/1ps
module ocfl_persist (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, low
  input wire logic disable_i, // channel suppressed
  input wire logic over_i, // level beyond trip limit
  input wire logic below_i, // level inside release band
  input wire logic hold_i, // keep trip until reset or disable_i
  input wire logic [ocfl_pkg::CNT_W-1:0] qual_i, // trip cycles
  output logic trip_o // channel tripped
);

  typedef enum logic [1:0] {OCFL_IDLE, OCFL_QUAL, OCFL_TRIP, OCFL_SETTLE} ocfl_pst_t;

  localparam logic [ocfl_pkg::CNT_W-1:0] SETTLE_END = ocfl_pkg::CNT_W'(ocfl_pkg::RELEASE_SETTLE_CYC - 1);

  ocfl_pst_t state_r;
  logic [ocfl_pkg::CNT_W-1:0] cnt_r;

  // ==========================================================
  // state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= OCFL_IDLE;
      cnt_r <= '0;
    end else if (disable_i) begin
      state_r <= OCFL_IDLE;
      cnt_r <= '0;
    end else begin
      case (state_r)
        OCFL_IDLE: begin
          cnt_r <= ocfl_pkg::CNT_W'(1);
          if (over_i) begin
            state_r <= (qual_i <= ocfl_pkg::CNT_W'(1)) ? OCFL_TRIP : OCFL_QUAL;
          end
        end
        OCFL_QUAL: begin
          if (!over_i) begin
            state_r <= OCFL_IDLE;
          end else if (cnt_r + ocfl_pkg::CNT_W'(1) >= qual_i) begin
            state_r <= OCFL_TRIP;
          end
          cnt_r <= cnt_r + ocfl_pkg::CNT_W'(1);
        end
        OCFL_TRIP: begin
          cnt_r <= '0;
          if (!hold_i && below_i) begin
            state_r <= OCFL_SETTLE;
          end
        end
        OCFL_SETTLE: begin
          if (hold_i || !below_i) begin
            state_r <= OCFL_TRIP;
          end else if (cnt_r >= SETTLE_END) begin
            state_r <= OCFL_IDLE;
          end
          cnt_r <= cnt_r + ocfl_pkg::CNT_W'(1);
        end
        default: begin
          state_r <= OCFL_IDLE;
          cnt_r <= '0;
        end
      endcase
    end
  end

  assign trip_o = (state_r == OCFL_TRIP) || (state_r == OCFL_SETTLE);

endmodule

// ---- rtl/ocfl_top.sv ----
// overcurrent fault decision, trim outputs and memory access locks
// assumes response samples on pclk, async pins for overvoltage and
// overtemperature, and an APB master for the configuration registers
`timescale 1ns/1ps

module ocfl_top #(
  parameter bit BIDIR = 1'b1 // bidirectional variant
) (
  input wire logic pclk, // clock 25 MHz
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic signed [15:0] resp_sample, // response, 0.1 %FS units
  input wire logic ot_trip_pin, // overtemperature comparator, async
  input wire logic hve_pin, // overvoltage entry detect, async
  input wire logic acc_valid, // memory access request
  input wire logic acc_write, // request is a write
  input wire logic acc_via_output, // request on sense output pin
  output logic acc_accept, // request accepted, pulse
  output logic acc_refuse, // request refused, pulse
  output logic signed [15:0] resp_out, // response after sign select
  output logic signed [15:0] gain_trim, // signed gain code
  output logic signed [15:0] offset_trim, // signed offset code
  output logic fault_n // fault pin, low on fault
);

  // ==========================================================
  // registers
  logic [31:0] trim_cfg_r;
  logic [31:0] fault_cfg_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic wr_en;
  logic rd_setup;
  logic addr_ok;
  logic [31:0] wmask;

  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign addr_ok = (paddr == ocfl_pkg::TRIM_CFG_OFS) || (paddr == ocfl_pkg::FAULT_CFG_OFS) ||
                   (paddr == ocfl_pkg::STATUS_OFS);

  // byte strobes expanded to a bit mask
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_mask
      assign wmask[gb*8 +: 8] = {8{pstrb[gb]}};
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_cfg_r <= ocfl_pkg::TRIM_CFG_RST;
    end else if (wr_en && paddr == ocfl_pkg::TRIM_CFG_OFS) begin
      trim_cfg_r <= ((trim_cfg_r & ~wmask) | (pwdata & wmask)) & ocfl_pkg::TRIM_CFG_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_cfg_r <= ocfl_pkg::FAULT_CFG_RST;
    end else if (wr_en && paddr == ocfl_pkg::FAULT_CFG_OFS) begin
      fault_cfg_r <= ((fault_cfg_r & ~wmask) | (pwdata & wmask)) & ocfl_pkg::FAULT_CFG_MASK;
    end
  end

  // ==========================================================
  // field views
  logic sign_sel;
  logic ot_dis;
  logic comm_inh;
  logic wr_lock;
  logic [ocfl_pkg::LIM_W-1:0] pos_overcurrent_limit;
  logic [ocfl_pkg::LIM_W-1:0] neg_overcurrent_limit;
  logic [ocfl_pkg::QUAL_W-1:0] overcurrent_persist_filter;
  logic [ocfl_pkg::HYST_W-1:0] overcurrent_release_margin;
  logic pos_trip_disable;
  logic neg_trip_disable;
  logic hold_en;

  assign sign_sel = trim_cfg_r[ocfl_pkg::SIGN_BIT];
  assign ot_dis = trim_cfg_r[ocfl_pkg::OT_DIS_BIT];
  assign comm_inh = trim_cfg_r[ocfl_pkg::COMM_INH_BIT];
  assign wr_lock = trim_cfg_r[ocfl_pkg::WR_LOCK_BIT];
  assign pos_overcurrent_limit = fault_cfg_r[ocfl_pkg::POS_LIM_LSB +: ocfl_pkg::LIM_W];
  assign neg_overcurrent_limit = fault_cfg_r[ocfl_pkg::NEG_LIM_LSB +: ocfl_pkg::LIM_W];
  assign overcurrent_persist_filter = fault_cfg_r[ocfl_pkg::QUAL_LSB +: ocfl_pkg::QUAL_W];
  assign overcurrent_release_margin = fault_cfg_r[ocfl_pkg::HYST_LSB +: ocfl_pkg::HYST_W];
  assign pos_trip_disable = fault_cfg_r[ocfl_pkg::POS_DIS_BIT];
  assign neg_trip_disable = fault_cfg_r[ocfl_pkg::NEG_DIS_BIT];
  assign hold_en = fault_cfg_r[ocfl_pkg::HOLD_BIT];

  // ==========================================================
  // pin synchronisers
  logic ot_meta_r;
  logic ot_sync_r;
  logic hve_meta_r;
  logic hve_sync_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ot_meta_r <= 1'b0;
      ot_sync_r <= 1'b0;
      hve_meta_r <= 1'b0;
      hve_sync_r <= 1'b0;
    end else begin
      ot_meta_r <= ot_trip_pin;
      ot_sync_r <= ot_meta_r;
      hve_meta_r <= hve_pin;
      hve_sync_r <= hve_meta_r;
    end
  end

  // ==========================================================
  // trim codes and response sign
  logic signed [16:0] resp_adj;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_trim <= 16'sh0000;
      offset_trim <= 16'sh0000;
    end else begin
      gain_trim <= 16'(signed'(trim_cfg_r[ocfl_pkg::GAIN_LSB +: ocfl_pkg::GAIN_W]));
      offset_trim <= 16'(signed'(trim_cfg_r[ocfl_pkg::OFFS_LSB +: ocfl_pkg::OFFS_W]));
    end
  end

  assign resp_adj = sign_sel ? 17'(resp_sample) : -17'(resp_sample);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_out <= 16'sh0000;
    end else if (resp_adj > 17'sh07fff) begin
      resp_out <= 16'sh7fff;
    end else begin
      resp_out <= 16'(resp_adj);
    end
  end

  // ==========================================================
  // trip and release levels
  logic signed [17:0] pos_lim_pm;
  logic signed [17:0] neg_lim_pm;
  logic signed [17:0] hyst_pm;
  logic signed [17:0] pos_hyst_pm;
  logic signed [17:0] neg_hyst_pm;
  logic signed [17:0] resp_ext;

  assign pos_lim_pm = 18'(ocfl_pkg::LIM_BASE_PM) + 18'(pos_overcurrent_limit) * 18'(ocfl_pkg::LIM_STEP_PM);
  assign neg_lim_pm = 18'(ocfl_pkg::LIM_BASE_PM) + 18'(neg_overcurrent_limit) * 18'(ocfl_pkg::LIM_STEP_PM);
  assign hyst_pm = 18'(ocfl_pkg::HYST_PM[overcurrent_release_margin]);
  assign pos_hyst_pm = (hyst_pm > pos_lim_pm - 18'(ocfl_pkg::HYST_FLOOR_PM)) ?
                       pos_lim_pm - 18'(ocfl_pkg::HYST_FLOOR_PM) : hyst_pm;
  assign neg_hyst_pm = (hyst_pm > neg_lim_pm - 18'(ocfl_pkg::HYST_FLOOR_PM)) ?
                       neg_lim_pm - 18'(ocfl_pkg::HYST_FLOOR_PM) : hyst_pm;
  assign resp_ext = 18'(resp_out);

  // ==========================================================
  // fault channels: 0 positive, 1 negative, 2 overtemperature
  logic [2:0] ch_dis;
  logic [2:0] ch_over;
  logic [2:0] ch_below;
  logic [ocfl_pkg::CNT_W-1:0] ch_qual [3];
  logic [2:0] ch_trip;

  assign ch_dis[0] = pos_trip_disable;
  assign ch_over[0] = resp_ext > pos_lim_pm;
  assign ch_below[0] = resp_ext < pos_lim_pm - pos_hyst_pm;
  assign ch_dis[1] = neg_trip_disable || !BIDIR;
  assign ch_over[1] = resp_ext < -neg_lim_pm;
  assign ch_below[1] = resp_ext > -(neg_lim_pm - neg_hyst_pm);
  assign ch_dis[2] = ot_dis;
  assign ch_over[2] = ot_sync_r;
  assign ch_below[2] = !ot_sync_r;
  assign ch_qual[0] = ocfl_pkg::qual_cycles(overcurrent_persist_filter);
  assign ch_qual[1] = ocfl_pkg::qual_cycles(overcurrent_persist_filter);
  assign ch_qual[2] = ocfl_pkg::CNT_W'(1);

  genvar gc;
  generate
    for (gc = 0; gc < 3; gc++) begin : g_ch
      ocfl_persist u_persist (
        .pclk(pclk),
        .presetn(presetn),
        .disable_i(ch_dis[gc]),
        .over_i(ch_over[gc]),
        .below_i(ch_below[gc]),
        .hold_i(hold_en),
        .qual_i(ch_qual[gc]),
        .trip_o(ch_trip[gc])
      );
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_n <= 1'b1;
    end else begin
      fault_n <= ~(|ch_trip);
    end
  end

  // ==========================================================
  // memory access gating
  logic hv_entered_r;
  logic path_ok;
  logic acc_ok;
  logic last_refused_r;

  // output path opens after overvoltage entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hv_entered_r <= 1'b0;
    end else if (hve_sync_r && !comm_inh) begin
      hv_entered_r <= 1'b1;
    end
  end

  assign path_ok = !acc_via_output || (!comm_inh && hv_entered_r);
  assign acc_ok = path_ok && !(acc_write && wr_lock);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_accept <= 1'b0;
      acc_refuse <= 1'b0;
    end else begin
      acc_accept <= acc_valid && acc_ok;
      acc_refuse <= acc_valid && !acc_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_refused_r <= 1'b0;
    end else if (acc_valid) begin
      last_refused_r <= !acc_ok;
    end
  end

  // ==========================================================
  // apb read path, data captured in setup cycle
  logic [31:0] status_w;

  assign status_w = {25'h0000000, last_refused_r, hv_entered_r, ~fault_n, ch_trip, 1'b0};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (rd_setup) begin
      pslverr_r <= !addr_ok || (pwrite && paddr == ocfl_pkg::STATUS_OFS);
      case (paddr)
        ocfl_pkg::TRIM_CFG_OFS: begin
          prdata_r <= trim_cfg_r;
        end
        ocfl_pkg::FAULT_CFG_OFS: begin
          prdata_r <= fault_cfg_r;
        end
        ocfl_pkg::STATUS_OFS: begin
          prdata_r <= status_w;
        end
        default: begin
          prdata_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign prdata = (psel && penable && !pwrite) ? prdata_r : 32'h0000_0000;
  assign pready = 1'b1;
  assign pslverr = psel && penable && pslverr_r;

endmodule

// ---- testbench/ocfl_top_props.sv ----
// checker for ocfl_top: access answers, trims, sign, fault timing
// assumes bind to ocfl_top; register values shadowed from apb writes
`timescale 1ns/1ps
module ocfl_props (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb data
  input wire logic [3:0] pstrb, // apb strobes
  input wire logic pready, // apb ready
  input wire logic signed [15:0] resp_sample, // response in
  input wire logic acc_valid, // access request
  input wire logic acc_write, // access write
  input wire logic acc_via_output, // output path
  input wire logic acc_accept, // accepted
  input wire logic acc_refuse, // refused
  input wire logic signed [15:0] resp_out, // response out
  input wire logic signed [15:0] gain_trim, // gain code
  input wire logic signed [15:0] offset_trim, // offset code
  input wire logic fault_n // fault pin
);
  // ==========================================
  // shadow registers and over-limit run counts
  logic [31:0] tr_r, fc_r, wm;
  logic [8:0] pc_r, nc_r;
  logic [1:0] up_r;
  int lp, ln, q;
  always_comb begin
    wm = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    lp = 500 + 16 * int'(fc_r[6:0]);
    ln = 500 + 16 * int'(fc_r[13:7]);
    q = ((ocfl_pkg::BASE_TRIP_NS + ocfl_pkg::QUAL_ADD_NS[fc_r[20:18]]) * 25 + 999) / 1000;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tr_r <= ocfl_pkg::TRIM_CFG_RST;
      fc_r <= 32'h0;
    end else if (psel && penable && pwrite && pready) begin
      if (paddr == ocfl_pkg::TRIM_CFG_OFS)
        tr_r <= (tr_r & ~wm | pwdata & wm) & ocfl_pkg::TRIM_CFG_MASK;
      if (paddr == ocfl_pkg::FAULT_CFG_OFS)
        fc_r <= (fc_r & ~wm | pwdata & wm) & ocfl_pkg::FAULT_CFG_MASK;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= 9'h0;
      nc_r <= 9'h0;
      up_r <= 2'h0;
    end else begin
      pc_r <= (resp_out > lp && !fc_r[22]) ? pc_r + 9'(pc_r != 9'h1ff) : 9'h0;
      nc_r <= (resp_out < -ln && !fc_r[21]) ? nc_r + 9'(nc_r != 9'h1ff) : 9'h0;
      up_r <= up_r + 2'(up_r != 2'h3);
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_acc_one;
    acc_valid |=> acc_accept != acc_refuse;
  endproperty
  a_acc_one: assert property (p_acc_one) else $error("access answer bad");
  property p_wlock;
    acc_valid && acc_write && tr_r[25] |=> acc_refuse;
  endproperty
  a_wlock: assert property (p_wlock) else $error("locked write taken");
  property p_inhibit;
    acc_valid && acc_via_output && tr_r[24] |=> acc_refuse;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibited path taken");
  property p_trim_pin;
    acc_valid && !acc_via_output && !(acc_write && tr_r[25]) |=> acc_accept;
  endproperty
  a_trim_pin: assert property (p_trim_pin) else $error("trim pin refused");
  property p_sign;
    up_r == 2'h3 && $stable(tr_r[21]) |-> resp_out == (tr_r[21] ? $past(resp_sample) : -$past(resp_sample));
  endproperty
  a_sign: assert property (p_sign) else $error("response sign wrong");
  property p_codes;
    up_r == 2'h3 && $stable(tr_r) |-> gain_trim == {{7{tr_r[8]}}, tr_r[8:0]}
      && offset_trim == {{7{tr_r[17]}}, tr_r[17:9]};
  endproperty
  a_codes: assert property (p_codes) else $error("trim code extension wrong");
  property p_qual;
    $fell(fault_n) |-> $past(pc_r) >= q || $past(nc_r) >= q || !tr_r[22];
  endproperty
  a_qual: assert property (p_qual) else $error("fault before persist time");
  property p_hold;
    !fault_n && fc_r[23] && $stable(fc_r) && fc_r[22:21] == 2'h0 |=> !fault_n;
  endproperty
  a_hold: assert property (p_hold) else $error("held fault released");
  property p_quiet;
    (fc_r[22] && fc_r[21] && tr_r[22])[*3] |-> fault_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("fault while all disabled");
endmodule
bind ocfl_top ocfl_props u_ocfl_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .pready, .resp_sample, .acc_valid, .acc_write, .acc_via_output, .acc_accept, .acc_refuse, .resp_out,
  .gain_trim, .offset_trim, .fault_n);

// ---- testbench/ocfl_trim_access_pin_model.sv ----
// external programmer: memory access requests and overvoltage entry
// assumes requests are answered one cycle after the strobe
`timescale 1ns/1ps
module ocfl_trim_access_pin_model (
  input wire logic pclk, // clock
  output logic acc_valid, // request strobe
  output logic acc_write, // write request
  output logic acc_via_output, // output path
  output logic hve_pin, // overvoltage level
  input wire logic acc_accept, // accepted
  input wire logic acc_refuse // refused
);
  // ==========================================
  // requests
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_via_output = 1'b0;
    hve_pin = 1'b0;
  end
  task automatic hv_entry(input logic lvl);
    @(posedge pclk);
    hve_pin <= lvl;
    repeat (4) @(posedge pclk);
  endtask
  task automatic req(input logic w, input logic via, output logic [1:0] ans);
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_via_output <= via;
    @(posedge pclk);
    acc_valid <= 1'b0;
    acc_write <= ~w;
    acc_via_output <= ~via;
    @(posedge pclk);
    ans = {acc_accept, acc_refuse};
  endtask
endmodule

// ---- testbench/ocfl_top_test.sv ----
// self-checking bench for ocfl_top: registers, access gate, fault timing
// assumes ocfl_trim_access_pin_model drives access requests and overvoltage level
`timescale 1ns/1ps
module ocfl_top_test;
  // ==========================================
  // signals and design
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic ot_trip_pin, hve_pin, acc_valid, acc_write, acc_via_output, acc_accept, acc_refuse, fault_n;
  logic signed [15:0] resp_sample, resp_out, gain_trim, offset_trim;
  int n_errors = 0;
  int checks_done = 0;
  localparam logic [7:0] TA = ocfl_pkg::TRIM_CFG_OFS;
  localparam logic [7:0] FA = ocfl_pkg::FAULT_CFG_OFS;
  localparam int ST = ocfl_pkg::RELEASE_SETTLE_CYC + 4;
  ocfl_top u_ocfl_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .resp_sample, .ot_trip_pin, .hve_pin, .acc_valid, .acc_write, .acc_via_output,
    .acc_accept, .acc_refuse, .resp_out, .gain_trim, .offset_trim, .fault_n);
  ocfl_trim_access_pin_model u_ocfl_trim_access_pin_model (.pclk, .acc_valid, .acc_write, .acc_via_output, .hve_pin,
    .acc_accept, .acc_refuse);
  always #20 pclk = ~pclk;
  // ==========================================
  // shared tasks
  task automatic end_sim;
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rst;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) begin
      n_errors++;
      end_sim;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // edges until fault_n shows lvl, 0 if not within lim
  task automatic run(input int v, input int lim, input logic lvl, output int n);
    resp_sample <= 16'(v);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (fault_n !== lvl && n < lim);
    if (fault_n !== lvl)
      n = 0;
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs;
    apb(1'b0, TA, 32'h0);
    chk("trim reset", ocfl_pkg::TRIM_CFG_RST, rdat);
    apb(1'b0, FA, 32'h0);
    chk("fault reset", 32'h0, rdat);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    apb(1'b1, TA, 32'hffff_ffff);
    apb(1'b0, TA, 32'h0);
    chk("trim mask", ocfl_pkg::TRIM_CFG_MASK, rdat);
    apb(1'b1, TA, 32'h0060_01ff);
    apb(1'b1, TA, 32'h0062_01ff);
    repeat (2) @(posedge pclk);
    chk("gain code", 32'hffff, {16'h0, gain_trim});
    chk("offset code", 32'hff00, {16'h0, offset_trim});
    pstrb <= 4'h1;
    apb(1'b1, TA, 32'h0);
    pstrb <= 4'hf;
    repeat (2) @(posedge pclk);
    chk("gain byte write", 32'hff00, {16'h0, gain_trim});
    resp_sample <= 16'sd100;
    repeat (2) @(posedge pclk);
    chk("resp default sign", 32'h64, {16'h0, resp_out});
    apb(1'b1, TA, 32'h0040_0000);
    repeat (2) @(posedge pclk);
    chk("resp reversed", 32'hff9c, {16'h0, resp_out});
    apb(1'b1, TA, ocfl_pkg::TRIM_CFG_RST);
  endtask
  task automatic t_access;
    logic [1:0] got;
    logic e;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 16; i++) begin
        apb(1'b1, TA, {6'h0, i[3], i[2], 8'h60, 16'h0});
        e = (!i[0] || (!i[2] && p == 1)) && !(i[1] && i[3]);
        u_ocfl_trim_access_pin_model.req(i[1], i[0], got);
        chk("access answer", {30'h0, e, !e}, {30'h0, got});
      end
      apb(1'b1, TA, ocfl_pkg::TRIM_CFG_RST);
      u_ocfl_trim_access_pin_model.hv_entry(1'b1);
      u_ocfl_trim_access_pin_model.hv_entry(1'b0);
    end
    apb(1'b0, ocfl_pkg::STATUS_OFS, 32'h0);
    chk("status", 32'h60, rdat);
  endtask
  task automatic t_qual;
    int q, n;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, FA, 32'(c) << 18);
      q = ((ocfl_pkg::BASE_TRIP_NS + ocfl_pkg::QUAL_ADD_NS[c]) * 25 + 999) / 1000;
      run(600, q - 1, 1'b0, n);
      run(0, 8, 1'b0, n);
      chk("short excursion", 32'(n), 32'h0);
      run(600, 500, 1'b0, n);
      chk("trip cycles", 32'(q + 3), 32'(n));
      run(0, 100, 1'b1, n);
      chk("release cycles", 32'(ST), 32'(n));
    end
  endtask
  task automatic t_hyst;
    int r, n;
    for (int h = 0; h < 4; h++) begin
      apb(1'b1, FA, (32'(h) << 24) | 32'h5);
      r = 580 - ((ocfl_pkg::HYST_PM[h] < 330) ? ocfl_pkg::HYST_PM[h] : 330);
      run(600, 500, 1'b0, n);
      run(r, 60, 1'b1, n);
      chk("no release at margin", 32'h0, 32'(n));
      run(r - 1, 60, 1'b1, n);
      chk("release below margin", 32'(ST), 32'(n));
    end
  endtask
  task automatic t_fault;
    int n;
    apb(1'b1, FA, 32'h0000_0500);
    run(-600, 100, 1'b0, n);
    chk("neg inside limit", 32'h0, 32'(n));
    run(-700, 100, 1'b0, n);
    chk("neg trip cycles", 32'd66, 32'(n));
    run(0, 100, 1'b1, n);
    apb(1'b1, FA, 32'h0060_0000);
    run(600, 100, 1'b0, n);
    chk("pos disabled", 32'h0, 32'(n));
    run(-700, 100, 1'b0, n);
    chk("neg disabled", 32'h0, 32'(n));
    apb(1'b1, FA, 32'h0080_0000);
    run(600, 100, 1'b0, n);
    chk("hold trip", 32'd66, 32'(n));
    run(0, 100, 1'b1, n);
    chk("hold keeps fault", 32'h0, 32'(n));
    rst;
    chk("reset frees fault", 32'h1, {31'h0, fault_n});
    apb(1'b1, TA, 32'h0020_0000);
    ot_trip_pin <= 1'b1;
    run(0, 20, 1'b0, n);
    chk("overtemp trips", 32'h1, 32'(n != 0));
    ot_trip_pin <= 1'b0;
    run(0, 60, 1'b1, n);
    chk("overtemp release", 32'h1, 32'(n != 0));
  endtask
  // ==========================================
  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pstrb = 4'hf;
    resp_sample = 16'sd0;
    ot_trip_pin = 1'b0;
    rst;
    t_regs;
    t_access;
    t_qual;
    t_hyst;
    t_fault;
    end_sim;
  end
endmodule
